//--- fmc_pkg.sv
// Purpose: constants for the fp min/max/classify unit and its status fields
// Assumes: 82-bit register format, classic wishbone register bus
// Notes: offsets are byte addresses on a 32-bit bus
package fmc_pkg;
    // register map
    localparam logic [7:0] ADDR_SF0 = 8'h00;
    localparam logic [7:0] ADDR_SF1 = 8'h04;
    localparam logic [7:0] ADDR_SF2 = 8'h08;
    localparam logic [7:0] ADDR_SF3 = 8'h0C;
    localparam logic [7:0] ADDR_TRAP_DIS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    // status field layout
    localparam int SF_W = 12;
    localparam int SF_RC_LO = 0;
    localparam int SF_PC_LO = 2;
    localparam int SF_WRE = 4;
    localparam int SF_TD = 5;
    localparam int SF_FLAG_LO = 6;
    localparam int FLAG_W = 6;
    localparam int FLAG_V = 0;
    localparam int FLAG_D = 1;
    localparam logic [11:0] SF_RESET = 12'h00C;
    localparam logic [5:0] TRAP_DIS_RESET = 6'h3F;
    // precision codes
    localparam logic [1:0] PC_SINGLE = 2'h0;
    localparam logic [1:0] PC_DOUBLE = 2'h2;
    localparam logic [1:0] PC_EXT = 2'h3;
    localparam logic [1:0] IPC_DYN = 2'h0;
    localparam logic [1:0] IPC_SINGLE = 2'h1;
    localparam logic [1:0] IPC_DOUBLE = 2'h2;
    // classify mask bits
    localparam int CM_POS = 0;
    localparam int CM_NEG = 1;
    localparam int CM_ZERO = 2;
    localparam int CM_UNORM = 3;
    localparam int CM_NORM = 4;
    localparam int CM_INF = 5;
    localparam int CM_SNAN = 6;
    localparam int CM_QNAN = 7;
    localparam int CM_NAT = 8;
    // interrupt bits
    localparam int IRQ_W = 2;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_FLAG = 1;
    typedef enum logic [2:0] {
        OP_MIN,
        OP_MAX,
        OP_AMIN,
        OP_AMAX,
        OP_CLASS
    } fmc_op_t;
endpackage : fmc_pkg

//--- fmc_unit.sv
// Purpose: fp min/max/amin/amax and classify with four selectable status fields
// Assumes: operands already in register format; one result per cycle, one cycle latency
// Notes: status fields, trap disables and interrupt registers on classic wishbone
// Notes on behaviour
// - there is a main status field and three more of the same layout, each with own bits.
// - every operation picks one of the four fields for its controls and its flags.
// - a field's controls set precision, range, rounding and the trap response.
// - all data widths share one register format, so operands need no conversion here.
// - single or double precision comes from the instruction, extended from the field.
// - the widened-range bit works with any of single, double or extended precision.
// - an ordered less-than is false whenever either input is a NaN.
// - min gives the first operand if it is less than the second, else the second.
// - max gives the first operand if the second is less than it, else the second.
// - amin and amax compare magnitudes without signs and otherwise act as min and max.
// - classify tests the operand against a mask of classes and writes two opposite predicates.
// - mask 0x1E3 matches the not-a-thing value, any NaN and either infinity.
// - mask 0x01A matches negative normals and negative unnormals.
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module fmc_unit #(
    parameter int EXP_W = 17,
    parameter int SIG_W = 64
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ,
    input wire logic OP_VALID,
    input wire logic [2:0] OP_CODE,
    input wire logic [1:0] OP_SF,
    input wire logic [1:0] OP_PC,
    input wire logic [8:0] OP_MASK,
    input wire logic [EXP_W+SIG_W:0] OP_A,
    input wire logic OP_NAT_A,
    input wire logic [EXP_W+SIG_W:0] OP_B,
    input wire logic OP_NAT_B,
    output logic RES_VALID,
    output logic RES_WRITE,
    output logic [EXP_W+SIG_W:0] RES_DATA,
    output logic RES_NAT,
    output logic RES_P1,
    output logic RES_P2,
    output logic RES_FAULT,
    output logic [1:0] RES_PC,
    output logic RES_WRE,
    output logic [1:0] RES_RC
);
    localparam int OPW = EXP_W + SIG_W + 1;

    // refuse widths that the nan and quiet-bit decode cannot serve
    if (EXP_W < 2 || SIG_W < 2) begin : g_bad_width
        $error("fmc_unit: exponent and significand need at least two bits");
    end

    logic [fmc_pkg::SF_W-1:0] sf [4];
    logic [5:0] trap_dis;
    logic [fmc_pkg::IRQ_W-1:0] irq_stat;
    logic [fmc_pkg::IRQ_W-1:0] irq_mask;

    // operand decode
    function automatic logic is_nan(input logic [OPW-1:0] x);
        is_nan = (&x[OPW-2:SIG_W]) && (x[SIG_W-2:0] != '0);
    endfunction : is_nan
    function automatic logic is_zero(input logic [OPW-1:0] x);
        is_zero = (x[SIG_W-1:0] == '0) && !(&x[OPW-2:SIG_W]);
    endfunction : is_zero
    // ordered less-than
    function automatic logic fp_lt(input logic [OPW-1:0] a, input logic [OPW-1:0] b);
        logic [OPW-2:0] ma;
        logic [OPW-2:0] mb;
        ma = a[OPW-2:0];
        mb = b[OPW-2:0];
        if (is_nan(a) || is_nan(b)) begin
            fp_lt = 1'b0;
        end else if (is_zero(a) && is_zero(b)) begin
            fp_lt = 1'b0;
        end else if (a[OPW-1] != b[OPW-1]) begin
            fp_lt = a[OPW-1];
        end else if (a[OPW-1]) begin
            fp_lt = ma > mb;
        end else begin
            fp_lt = ma < mb;
        end
    endfunction : fp_lt

    fmc_pkg::fmc_op_t op;
    logic [fmc_pkg::SF_W-1:0] cur_sf;
    logic [OPW-1:0] abs_a;
    logic [OPW-1:0] abs_b;
    logic a_lt_b;
    logic b_lt_a;
    logic is_mm;
    logic any_nat;
    logic [OPW-1:0] next_res;
    logic [fmc_pkg::FLAG_W-1:0] new_flags;
    logic trap;
    logic a_exp_max;
    logic a_snan;
    logic a_qnan;
    logic a_inf;
    logic a_zero;
    logic a_unorm;
    logic a_norm;
    logic a_sign_ok;
    logic class_hit;
    logic [1:0] next_pc;

    assign op = fmc_pkg::fmc_op_t'(OP_CODE);
    assign cur_sf = sf[OP_SF];
    assign abs_a = {1'b0, OP_A[OPW-2:0]};
    assign abs_b = {1'b0, OP_B[OPW-2:0]};
    assign is_mm = OP_VALID && (op != fmc_pkg::OP_CLASS);
    assign any_nat = OP_NAT_A || OP_NAT_B;

    always_comb begin
        a_lt_b = fp_lt(OP_A, OP_B);
        b_lt_a = fp_lt(OP_B, OP_A);
        case (op)
            fmc_pkg::OP_MIN: next_res = a_lt_b ? OP_A : OP_B;
            fmc_pkg::OP_MAX: next_res = b_lt_a ? OP_A : OP_B;
            fmc_pkg::OP_AMIN: next_res = fp_lt(abs_a, abs_b) ? OP_A : OP_B;
            fmc_pkg::OP_AMAX: next_res = fp_lt(abs_b, abs_a) ? OP_A : OP_B;
            default: next_res = OP_B;
        endcase
    end

    // flags raised by a compare: invalid on NaN, denormal on zero-exponent nonzero
    always_comb begin
        new_flags = '0;
        new_flags[fmc_pkg::FLAG_V] = is_nan(OP_A) || is_nan(OP_B);
        new_flags[fmc_pkg::FLAG_D] = ((OP_A[OPW-2:SIG_W] == '0) && !is_zero(OP_A))
            || ((OP_B[OPW-2:SIG_W] == '0) && !is_zero(OP_B));
    end
    // trap response taken from the selected field
    assign trap = is_mm && !any_nat && !cur_sf[fmc_pkg::SF_TD]
        && ((new_flags & ~trap_dis) != '0);

    // classify
    assign a_exp_max = &OP_A[OPW-2:SIG_W];
    assign a_snan = a_exp_max && (OP_A[SIG_W-2:0] != '0) && !OP_A[SIG_W-2];
    assign a_qnan = a_exp_max && OP_A[SIG_W-2];
    assign a_inf = a_exp_max && (OP_A[SIG_W-2:0] == '0);
    assign a_zero = is_zero(OP_A);
    assign a_norm = !a_exp_max && OP_A[SIG_W-1];
    assign a_unorm = !a_exp_max && !OP_A[SIG_W-1] && !a_zero;
    assign a_sign_ok = OP_A[OPW-1] ? OP_MASK[fmc_pkg::CM_NEG] : OP_MASK[fmc_pkg::CM_POS];
    always_comb begin
        if (OP_NAT_A) begin
            class_hit = OP_MASK[fmc_pkg::CM_NAT];
        end else if (a_snan || a_qnan) begin
            class_hit = (a_snan && OP_MASK[fmc_pkg::CM_SNAN])
                || (a_qnan && OP_MASK[fmc_pkg::CM_QNAN]);
        end else begin
            class_hit = a_sign_ok && ((a_inf && OP_MASK[fmc_pkg::CM_INF])
                || (a_zero && OP_MASK[fmc_pkg::CM_ZERO])
                || (a_norm && OP_MASK[fmc_pkg::CM_NORM])
                || (a_unorm && OP_MASK[fmc_pkg::CM_UNORM]));
        end
    end

    // precision: static single/double, else the field's own
    always_comb begin
        case (OP_PC)
            fmc_pkg::IPC_SINGLE: next_pc = fmc_pkg::PC_SINGLE;
            fmc_pkg::IPC_DOUBLE: next_pc = fmc_pkg::PC_DOUBLE;
            default: next_pc = cur_sf[fmc_pkg::SF_PC_LO +: 2];
        endcase
    end

    // result stage
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            RES_VALID <= 1'b0;
            RES_WRITE <= 1'b0;
            RES_DATA <= '0;
            RES_NAT <= 1'b0;
            RES_P1 <= 1'b0;
            RES_P2 <= 1'b0;
            RES_FAULT <= 1'b0;
            RES_PC <= fmc_pkg::PC_EXT;
            RES_WRE <= 1'b0;
            RES_RC <= 2'h0;
        end else begin
            RES_VALID <= OP_VALID;
            RES_WRITE <= is_mm && !trap;
            RES_DATA <= next_res;
            RES_NAT <= is_mm && any_nat;
            RES_P1 <= OP_VALID && (op == fmc_pkg::OP_CLASS) && class_hit;
            RES_P2 <= OP_VALID && (op == fmc_pkg::OP_CLASS) && !class_hit;
            RES_FAULT <= trap;
            RES_PC <= next_pc;
            RES_WRE <= cur_sf[fmc_pkg::SF_WRE];
            RES_RC <= cur_sf[fmc_pkg::SF_RC_LO +: 2];
        end
    end

    // wishbone slave
    logic bus_req;
    logic bus_wr;
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign bus_wr = bus_req && WB_WE_I;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= '0;
            if (bus_req && !WB_WE_I) begin
                case (WB_ADR_I)
                    fmc_pkg::ADDR_SF0: WB_DAT_O <= 32'(sf[0]);
                    fmc_pkg::ADDR_SF1: WB_DAT_O <= 32'(sf[1]);
                    fmc_pkg::ADDR_SF2: WB_DAT_O <= 32'(sf[2]);
                    fmc_pkg::ADDR_SF3: WB_DAT_O <= 32'(sf[3]);
                    fmc_pkg::ADDR_TRAP_DIS: WB_DAT_O <= 32'(trap_dis);
                    fmc_pkg::ADDR_IRQ_STAT: WB_DAT_O <= 32'(irq_stat);
                    fmc_pkg::ADDR_IRQ_MASK: WB_DAT_O <= 32'(irq_mask);
                    default: WB_DAT_O <= '0;
                endcase
            end
        end
    end

    // status fields: byte-lane writes, hardware flag sets win
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sf
            logic hit;
            logic [fmc_pkg::SF_W-1:0] wval;
            logic [fmc_pkg::SF_W-1:0] hw_set;
            assign hit = bus_wr && (WB_ADR_I == 8'(gi * 4));
            assign wval = {WB_SEL_I[1] ? WB_DAT_I[11:8] : sf[gi][11:8],
                           WB_SEL_I[0] ? WB_DAT_I[7:0] : sf[gi][7:0]};
            assign hw_set = (is_mm && !any_nat && !trap && OP_SF == 2'(gi))
                ? (fmc_pkg::SF_W'(new_flags) << fmc_pkg::SF_FLAG_LO) : '0;
            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    sf[gi] <= fmc_pkg::SF_RESET;
                end else begin
                    sf[gi] <= (hit ? wval : sf[gi]) | hw_set;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            trap_dis <= fmc_pkg::TRAP_DIS_RESET;
            irq_mask <= '0;
        end else begin
            if (bus_wr && WB_SEL_I[0] && WB_ADR_I == fmc_pkg::ADDR_TRAP_DIS) begin
                trap_dis <= WB_DAT_I[5:0];
            end
            if (bus_wr && WB_SEL_I[0] && WB_ADR_I == fmc_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= WB_DAT_I[fmc_pkg::IRQ_W-1:0];
            end
        end
    end

    // interrupts: write one to clear, set wins
    logic [fmc_pkg::IRQ_W-1:0] irq_set;
    logic [fmc_pkg::IRQ_W-1:0] irq_clr;
    assign irq_set = {is_mm && !any_nat && !trap && (new_flags != '0), trap};
    assign irq_clr = (bus_wr && WB_SEL_I[0] && WB_ADR_I == fmc_pkg::ADDR_IRQ_STAT)
        ? WB_DAT_I[fmc_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            irq_stat <= '0;
            IRQ <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            IRQ <= ((irq_stat & irq_mask) != '0);
        end
    end

    // checks
    chk_min_select: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && op == fmc_pkg::OP_MIN) |=> RES_DATA == ($past(a_lt_b) ? $past(OP_A) : $past(OP_B)))
        else $error("min picked the wrong operand");
    chk_max_select: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && op == fmc_pkg::OP_MAX) |=> RES_DATA == ($past(b_lt_a) ? $past(OP_A) : $past(OP_B)))
        else $error("max picked the wrong operand");
    chk_nan_order: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && op == fmc_pkg::OP_MIN && is_nan(OP_A)) |=> RES_DATA == $past(OP_B))
        else $error("nan compared as ordered");
    chk_amin_sign: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && op == fmc_pkg::OP_AMIN && OP_A[OPW-2:0] == OP_B[OPW-2:0])
        |=> RES_DATA == $past(OP_B))
        else $error("amin did not ignore the sign");
    chk_class_pair: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && op == fmc_pkg::OP_CLASS) |=> (RES_P1 != RES_P2) && RES_VALID && !RES_WRITE)
        else $error("classify predicates not complementary");
    chk_class_nat: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && op == fmc_pkg::OP_CLASS && OP_NAT_A && OP_MASK == 9'h1E3) |=> RES_P1)
        else $error("nat value missed by mask");
    chk_class_negn: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && op == fmc_pkg::OP_CLASS && OP_MASK == 9'h01A && !OP_NAT_A
         && OP_A[OPW-1] && a_norm) |=> RES_P1)
        else $error("negative normal missed by mask");
    chk_flag_route: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (is_mm && !any_nat && !trap && is_nan(OP_A))
        |=> sf[$past(OP_SF)][fmc_pkg::SF_FLAG_LO + fmc_pkg::FLAG_V])
        else $error("invalid flag not set in selected field");
    chk_prec_static: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (OP_VALID && OP_PC == fmc_pkg::IPC_SINGLE) |=> RES_PC == fmc_pkg::PC_SINGLE)
        else $error("static precision ignored");
    chk_trap_block: assert property (@(posedge CLOCK) disable iff (!RST_N)
        trap |=> RES_FAULT && !RES_WRITE ##1 irq_stat[fmc_pkg::IRQ_FAULT])
        else $error("trap did not fault");
endmodule : fmc_unit

//--- fmc_issue_model.sv
// Purpose: issue side and result capture for the fp min/max/classify unit
// Assumes: one operation per go pulse, results return in order
// Notes: request packed as {code, sf, pc, mask, a, nat_a, b}
`timescale 1ns/10ps
module fmc_issue_model (
    input wire logic CLOCK,
    input wire logic go,
    input wire logic [180:0] req,
    input wire logic res_valid,
    input wire logic [9:0] res_flags,
    input wire logic [81:0] res_data,
    output logic op_valid,
    output logic [180:0] op_bus,
    output logic got,
    output logic [9:0] res,
    output logic [81:0] data
);
    // one process owns every output, so each has a single driver
    initial begin
        {op_valid, op_bus, got, res, data} = '0;
        // operands always travel in the one register format, selector with them
        forever begin
            @(posedge CLOCK);
            op_valid <= go;
            if (go) begin
                op_bus <= req;
            end
            if (go) begin
                got <= 1'b0;
            end else if (res_valid) begin
                {got, res, data} <= {1'b1, res_flags, res_data};
            end
        end
    end
endmodule : fmc_issue_model

//--- fmc_unit_tb.sv
// Purpose: self-checking bench for the fp min/max/classify unit
// Assumes: default 82-bit register format, classic wishbone register access
// Notes: operations go through the issue model
`timescale 1ns/10ps
module fmc_unit_tb;
    localparam logic [63:0] M1 = 64'h8000_0000_0000_0000;
    localparam logic [81:0] P1 = {1'b0, 17'h0FFFF, M1};
    localparam logic [81:0] P2 = {1'b0, 17'h10000, M1};
    localparam logic [81:0] N2 = {1'b1, 17'h10000, M1};
    localparam logic [81:0] QN = {1'b0, 17'h1FFFF, 64'hC000_0000_0000_0000};
    localparam logic [81:0] SN = {1'b0, 17'h1FFFF, 64'h8000_0000_0000_0001};
    localparam logic [81:0] PI = {1'b0, 17'h1FFFF, M1};
    localparam logic [81:0] NI = {1'b1, 17'h1FFFF, M1};
    localparam logic [81:0] NU = {1'b1, 17'h0FFFF, 64'h4000_0000_0000_0000};
    localparam logic [81:0] MV [4] = '{P1, P2, N2, QN};
    localparam logic [81:0] CV [8] = '{P1, QN, SN, PI, NI, N2, NU, P1};
    localparam logic [7:0] MT [17] = '{8'h03, 8'h08, 8'h18, 8'h06, 8'h00, 8'h22, 8'h29, 8'h38,
        8'h26, 8'h11, 8'h50, 8'h45, 8'h71, 8'h30, 8'h64, 8'h52, 8'h6C};
    localparam logic [7:0] PCT = 8'hE3;
    logic CLOCK, RST_N, cyc, stb, we, go, ov, got;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [180:0] req, ob;
    logic [9:0] res;
    logic [81:0] data;
    wire [31:0] rdat;
    wire ack, irq, rv;
    wire [9:0] rf;
    wire [81:0] rd;
    int fail_count, tests_run;
    fmc_unit fmc_unit_i (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ(irq), .OP_VALID(ov), .OP_CODE(ob[180:178]), .OP_SF(ob[177:176]),
        .OP_PC(ob[175:174]), .OP_MASK(ob[173:165]), .OP_A(ob[164:83]), .OP_NAT_A(ob[82]),
        .OP_B(ob[81:0]), .OP_NAT_B(1'b0), .RES_VALID(rv), .RES_WRITE(rf[9]), .RES_DATA(rd),
        .RES_NAT(rf[5]), .RES_P1(rf[7]), .RES_P2(rf[6]), .RES_FAULT(rf[8]), .RES_PC(rf[4:3]),
        .RES_WRE(rf[2]), .RES_RC(rf[1:0]));
    fmc_issue_model fmc_issue_model_i (.CLOCK(CLOCK), .go(go), .req(req), .res_valid(rv),
        .res_flags(rf), .res_data(rd), .op_valid(ov), .op_bus(ob), .got(got), .res(res),
        .data(data));
    task automatic chk(input logic [81:0] g, input logic [81:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic wait_on(input int n);
        if (n >= 40) begin
            fail_count++;
            end_sim();
        end
    endtask : wait_on
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, ad, d};
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        {cyc, stb} <= 2'b00;
        wait_on(n);
        @(posedge CLOCK);
    endtask : wb
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, ad, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, ad, 32'h0, q);
        chk(q, e);
    endtask : rdc
    task automatic run_op(input logic [2:0] c, input logic [1:0] s, input logic [1:0] p,
            input logic [8:0] m, input logic [81:0] x, input logic xn, input logic [81:0] y);
        int n;
        req <= {c, s, p, m, x, xn, y};
        go <= 1'b1;
        @(posedge CLOCK);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (got !== 1'b1 && n < 40);
        wait_on(n);
    endtask : run_op
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    initial begin
        logic [7:0] t;
        logic [1:0] fp;
        logic [7:0] fa;
        {RST_N, cyc, stb, we, go, adr, wdat, req} <= '0;
        sel <= 4'hF;
        fail_count = 0;
        tests_run = 0;
        repeat (20) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        for (int k = 0; k < 4; k++) rdc(fmc_pkg::ADDR_SF0 + 8'(4 * k), 32'h00C);
        rdc(fmc_pkg::ADDR_TRAP_DIS, 32'h3F);
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C, 32'h0);
        for (int i = 0; i < 17; i++) begin
            t = MT[i];
            run_op(t[7:5], 2'h0, fmc_pkg::IPC_DYN, 9'h0, MV[t[4:3]], 1'b0, MV[t[2:1]]);
            chk(data, t[0] ? MV[t[4:3]] : MV[t[2:1]]);
            chk(res[9], 1'b1);
        end
        for (int i = 0; i < 16; i++) begin
            t = i[3] ? 8'h60 : 8'h9E;
            run_op(3'h4, 2'h0, fmc_pkg::IPC_DYN, i[3] ? 9'h01A : 9'h1E3, CV[i[2:0]],
                i[2:0] == 3'h7, P2);
            chk({res[9], res[7:6]}, {1'b0, t[i[2:0]], ~t[i[2:0]]});
        end
        for (int k = 0; k < 4; k++) begin
            fp = PCT[2 * k +: 2];
            fa = fmc_pkg::ADDR_SF0 + 8'(4 * k);
            wr(fa, 32'({k[0], fp, k[1:0]}));
            rdc(fa, 32'({k[0], fp, k[1:0]}));
            run_op(3'h4, k[1:0], fmc_pkg::IPC_DYN, 9'h0, P1, 1'b0, P1);
            chk(res[4:0], {fp, k[0], k[1:0]});
            run_op(3'h4, k[1:0], fmc_pkg::IPC_SINGLE, 9'h0, P1, 1'b0, P1);
            chk(res[4:3], fmc_pkg::PC_SINGLE);
            run_op(3'h4, k[1:0], fmc_pkg::IPC_DOUBLE, 9'h0, P1, 1'b0, P1);
            chk(res[4:3], fmc_pkg::PC_DOUBLE);
        end
        // low byte lane only: upper flag nibble of field one must stay
        sel <= 4'h1;
        wr(fmc_pkg::ADDR_SF1, 32'hFFF);
        sel <= 4'hF;
        rdc(fmc_pkg::ADDR_SF1, 32'h0FF);
        wr(fmc_pkg::ADDR_IRQ_STAT, 32'h3);
        run_op(3'h0, 2'h3, fmc_pkg::IPC_DYN, 9'h0, QN, 1'b0, P1);
        rdc(fmc_pkg::ADDR_SF3, 32'h05F);
        rdc(fmc_pkg::ADDR_SF0, 32'h00C);
        rdc(fmc_pkg::ADDR_IRQ_STAT, 32'h2);
        chk(irq, 1'b0);
        wr(fmc_pkg::ADDR_TRAP_DIS, 32'h3E);
        run_op(3'h0, 2'h0, fmc_pkg::IPC_DYN, 9'h0, QN, 1'b0, P1);
        chk(res[9:8], 2'b01);
        // nat input: result marked nat, written, no trap and no flags
        run_op(3'h0, 2'h0, fmc_pkg::IPC_DYN, 9'h0, QN, 1'b1, P1);
        chk(res[9:5], 5'b10001);
        chk(data, P1);
        rdc(fmc_pkg::ADDR_SF0, 32'h00C);
        wr(fmc_pkg::ADDR_SF0, 32'h02C);
        run_op(3'h0, 2'h0, fmc_pkg::IPC_DYN, 9'h0, QN, 1'b0, P1);
        chk(res[9:8], 2'b10);
        rdc(fmc_pkg::ADDR_IRQ_STAT, 32'h3);
        wr(fmc_pkg::ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge CLOCK);
        chk(irq, 1'b1);
        wr(fmc_pkg::ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge CLOCK);
        chk(irq, 1'b0);
        rdc(fmc_pkg::ADDR_IRQ_STAT, 32'h2);
        end_sim();
    end
endmodule : fmc_unit_tb
